// >>> hw/timer_pkg.sv
// Constants for the dual timer/counter unit
// Operation
// - With gate enabled, a timer counts only while its gate pin is high and run set.
// - Gated and running, the counter steps on each falling edge of its count pin.
// - Count select 1 counts pin events, 0 counts machine cycles.
// - Mode field 00 13-bit, 01 16-bit, 10 8-bit reload, 11 special.
// - Mode 0 uses 5 low bits plus high byte; low byte top 3 bits stay zero.
// - Mode 2 low byte counts; on overflow the high byte is reloaded into it.
// - Timer 1 in mode 11 stops.
// - Timer 0 in mode 11 becomes two independent 8-bit counters.
// - Split low byte uses run 0, gate, flag 0; high byte run 1, flag 1.
// - Overflow sets a flag; software or interrupt service clears it.
// - A cleared run bit holds its timer stopped; setting it starts it.
// - Falling edge on a gate pin sets its edge flag; service clears it.
// - Trigger type bit picks falling edge or low level for each external interrupt.
// - Timer counting steps once per machine cycle of twelve clocks.
// - Count pin falls are seen over two machine cycles; gate pin falls and low levels are sampled every clock.
package timer_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CLKS_PER_MACHINE_CYCLE = 12;
    localparam logic [3:0] PRESCALE_LAST = 4'(CLKS_PER_MACHINE_CYCLE - 1);
    // Word offsets on the bus
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h04;
    localparam logic [7:0] LOW0_OFS = 8'h08;
    localparam logic [7:0] HIGH0_OFS = 8'h0C;
    localparam logic [7:0] LOW1_OFS = 8'h10;
    localparam logic [7:0] HIGH1_OFS = 8'h14;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h18;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h1C;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h20;
    // Mode register fields, timer 1 in the upper nibble
    localparam int unsigned MODE_T1_LSB = 4;
    localparam int unsigned MODE_SEL_LSB = 0;
    localparam int unsigned COUNT_SELECT_BIT = 2;
    localparam int unsigned GATE_ENABLE_BIT = 3;
    // Control register fields
    localparam int unsigned TRIGGER_TYPE_0_BIT = 0;
    localparam int unsigned EDGE_FLAG_0_BIT = 1;
    localparam int unsigned TRIGGER_TYPE_1_BIT = 2;
    localparam int unsigned EDGE_FLAG_1_BIT = 3;
    localparam int unsigned RUN_BIT_0_BIT = 4;
    localparam int unsigned OVERFLOW_FLAG_0_BIT = 5;
    localparam int unsigned RUN_BIT_1_BIT = 6;
    localparam int unsigned OVERFLOW_FLAG_1_BIT = 7;
    // Interrupt status layout
    localparam int unsigned EV_OVF0 = 0;
    localparam int unsigned EV_OVF1 = 1;
    localparam int unsigned EV_EXT0 = 2;
    localparam int unsigned EV_EXT1 = 3;
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPECIAL = 2'h3;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
endpackage

// >>> hw/dual_timer_counter_unit.sv
// Two timer/counters with mode and control registers on a Wishbone slave
`timescale 1ns/1ps
module dual_timer_counter_unit (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic count_pin_0,
    input wire logic count_pin_1,
    input wire logic irq_gate_pin_0,
    input wire logic irq_gate_pin_1,
    input wire logic [3:0] svc_ack,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Counter step: returns {overflow, high byte, low byte}
    function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] lo,
                                         input logic [7:0] hi);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8 = {1'b0, lo} + 9'h001;
        case (m)
            timer_pkg::MODE_13BIT: step = {s13[13], s13[12:5], 3'h0, s13[4:0]};
            timer_pkg::MODE_16BIT: step = s16;
            timer_pkg::MODE_RELOAD: step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
            default: step = {s8[8], hi, s8[7:0]};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] mode_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] low0_ff;
    logic [7:0] high0_ff;
    logic [7:0] low1_ff;
    logic [7:0] high1_ff;
    logic [3:0] irq_status_ff;
    logic [3:0] irq_enable_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [3:0] pre_ff;
    logic [1:0] cnt_meta_ff;
    logic [1:0] cnt_sync_ff;
    logic [1:0] cnt_smp_ff;
    logic [1:0] gate_meta_ff;
    logic [1:0] gate_sync_ff;
    logic [1:0] gate_prev_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: ack one cycle after the request, writes commit on the ack edge
    logic req;
    logic wr;
    logic [7:0] rd;
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & ack_ff & wb_sel_i[0];
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    always_comb begin
        if (wb_adr_i == timer_pkg::MODE_OFS) begin
            rd = mode_ff;
        end else if (wb_adr_i == timer_pkg::CTRL_OFS) begin
            rd = ctrl_ff;
        end else if (wb_adr_i == timer_pkg::LOW0_OFS) begin
            rd = low0_ff;
        end else if (wb_adr_i == timer_pkg::HIGH0_OFS) begin
            rd = high0_ff;
        end else if (wb_adr_i == timer_pkg::LOW1_OFS) begin
            rd = low1_ff;
        end else if (wb_adr_i == timer_pkg::HIGH1_OFS) begin
            rd = high1_ff;
        end else if (wb_adr_i == timer_pkg::IRQ_STATUS_OFS) begin
            rd = {4'h0, irq_status_ff};
        end else if (wb_adr_i == timer_pkg::IRQ_ENABLE_OFS) begin
            rd = {4'h0, irq_enable_ff};
        end else begin
            rd = 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else begin
            ack_ff <= req & ~ack_ff;
            if (req & ~ack_ff) begin
                dat_ff <= {24'h000000, rd};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Machine cycle prescaler and pin synchronisers
    logic mc_tick;
    assign mc_tick = (pre_ff == timer_pkg::PRESCALE_LAST);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pre_ff <= 4'h0;
        end else begin
            pre_ff <= mc_tick ? 4'h0 : pre_ff + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_meta_ff <= 2'h3;
            cnt_sync_ff <= 2'h3;
            gate_meta_ff <= 2'h3;
            gate_sync_ff <= 2'h3;
            gate_prev_ff <= 2'h3;
        end else begin
            cnt_meta_ff <= {count_pin_1, count_pin_0};
            cnt_sync_ff <= cnt_meta_ff;
            gate_meta_ff <= {irq_gate_pin_1, irq_gate_pin_0};
            gate_sync_ff <= gate_meta_ff;
            gate_prev_ff <= gate_sync_ff;
        end
    end

    // Count pins are looked at once per machine cycle, so a fall spans two samples
    logic [1:0] cnt_fall;
    assign cnt_fall = {2{mc_tick}} & cnt_smp_ff & ~cnt_sync_ff;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_smp_ff <= 2'h3;
        end else if (mc_tick) begin
            cnt_smp_ff <= cnt_sync_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count enables
    logic [1:0] m0;
    logic [1:0] m1;
    logic run0;
    logic run1;
    logic en0;
    logic en1;
    logic inc0;
    logic inc1;
    logic inc0_hi;
    logic split;
    logic [16:0] nxt_t0;
    logic [16:0] nxt_t1;
    logic [16:0] nxt_hi0;
    assign m0 = mode_ff[timer_pkg::MODE_SEL_LSB +: 2];
    assign m1 = mode_ff[timer_pkg::MODE_T1_LSB + timer_pkg::MODE_SEL_LSB +: 2];
    assign run0 = ctrl_ff[timer_pkg::RUN_BIT_0_BIT];
    assign run1 = ctrl_ff[timer_pkg::RUN_BIT_1_BIT];
    assign split = (m0 == timer_pkg::MODE_SPECIAL);
    assign en0 = run0 & (~mode_ff[timer_pkg::GATE_ENABLE_BIT] | gate_sync_ff[0]);
    assign en1 = run1 &
        (~mode_ff[timer_pkg::MODE_T1_LSB + timer_pkg::GATE_ENABLE_BIT] | gate_sync_ff[1]);
    assign inc0 = en0 & (mode_ff[timer_pkg::COUNT_SELECT_BIT] ? cnt_fall[0] : mc_tick);
    assign inc1 = en1 & (m1 != timer_pkg::MODE_SPECIAL) &
        (mode_ff[timer_pkg::MODE_T1_LSB + timer_pkg::COUNT_SELECT_BIT] ?
         cnt_fall[1] : mc_tick);
    // Split high byte is a plain machine-cycle timer on run 1
    assign inc0_hi = split & run1 & mc_tick;
    assign nxt_t0 = step(m0, low0_ff, high0_ff);
    assign nxt_t1 = step(m1, low1_ff, high1_ff);
    assign nxt_hi0 = step(timer_pkg::MODE_SPECIAL, high0_ff, 8'h00);

    logic ovf0;
    logic ovf1;
    assign ovf0 = inc0 & nxt_t0[16];
    // With timer 0 split, the high byte owns overflow flag 1
    assign ovf1 = split ? (inc0_hi & nxt_hi0[16]) : (inc1 & nxt_t1[16]);

    ////////////////////////////////////////////////////////////////////////////
    // Count bytes: a software write overrides a same-cycle step
    logic wr_low0;
    logic wr_high0;
    logic wr_low1;
    logic wr_high1;
    assign wr_low0 = wr & (wb_adr_i == timer_pkg::LOW0_OFS);
    assign wr_high0 = wr & (wb_adr_i == timer_pkg::HIGH0_OFS);
    assign wr_low1 = wr & (wb_adr_i == timer_pkg::LOW1_OFS);
    assign wr_high1 = wr & (wb_adr_i == timer_pkg::HIGH1_OFS);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            low0_ff <= timer_pkg::COUNT_RESET;
            high0_ff <= timer_pkg::COUNT_RESET;
        end else begin
            if (wr_low0) begin
                low0_ff <= wb_dat_i[7:0];
            end else if (inc0) begin
                low0_ff <= nxt_t0[7:0];
            end else if (m0 == timer_pkg::MODE_13BIT) begin
                low0_ff <= {3'h0, low0_ff[4:0]};
            end
            if (wr_high0) begin
                high0_ff <= wb_dat_i[7:0];
            end else if (split) begin
                if (inc0_hi) begin
                    high0_ff <= nxt_hi0[7:0];
                end
            end else if (inc0) begin
                high0_ff <= nxt_t0[15:8];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            low1_ff <= timer_pkg::COUNT_RESET;
            high1_ff <= timer_pkg::COUNT_RESET;
        end else begin
            if (wr_low1) begin
                low1_ff <= wb_dat_i[7:0];
            end else if (inc1) begin
                low1_ff <= nxt_t1[7:0];
            end else if (m1 == timer_pkg::MODE_13BIT) begin
                low1_ff <= {3'h0, low1_ff[4:0]};
            end
            if (wr_high1) begin
                high1_ff <= wb_dat_i[7:0];
            end else if (inc1) begin
                high1_ff <= nxt_t1[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode and control registers; hardware sets win over any clear
    logic [1:0] ext_set;
    logic ty0;
    logic ty1;
    logic wr_ctrl;
    assign ty0 = ctrl_ff[timer_pkg::TRIGGER_TYPE_0_BIT];
    assign ty1 = ctrl_ff[timer_pkg::TRIGGER_TYPE_1_BIT];
    // Type 1 is falling edge, type 0 is low level
    assign ext_set[0] = ty0 ? (gate_prev_ff[0] & ~gate_sync_ff[0]) : ~gate_sync_ff[0];
    assign ext_set[1] = ty1 ? (gate_prev_ff[1] & ~gate_sync_ff[1]) : ~gate_sync_ff[1];
    assign wr_ctrl = wr & (wb_adr_i == timer_pkg::CTRL_OFS);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_ff <= timer_pkg::MODE_RESET;
        end else if (wr & (wb_adr_i == timer_pkg::MODE_OFS)) begin
            mode_ff <= wb_dat_i[7:0];
        end
    end

    logic [7:0] cbase;
    always_comb begin
        cbase = wr_ctrl ? wb_dat_i[7:0] : ctrl_ff;
        // Service acknowledge clears the flag unless software rewrote it
        if (!wr_ctrl) begin
            cbase[timer_pkg::OVERFLOW_FLAG_0_BIT] = ctrl_ff[timer_pkg::OVERFLOW_FLAG_0_BIT] &
                ~svc_ack[timer_pkg::EV_OVF0];
            cbase[timer_pkg::OVERFLOW_FLAG_1_BIT] = ctrl_ff[timer_pkg::OVERFLOW_FLAG_1_BIT] &
                ~svc_ack[timer_pkg::EV_OVF1];
            cbase[timer_pkg::EDGE_FLAG_0_BIT] = ctrl_ff[timer_pkg::EDGE_FLAG_0_BIT] &
                ~svc_ack[timer_pkg::EV_EXT0];
            cbase[timer_pkg::EDGE_FLAG_1_BIT] = ctrl_ff[timer_pkg::EDGE_FLAG_1_BIT] &
                ~svc_ack[timer_pkg::EV_EXT1];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_ff <= timer_pkg::CTRL_RESET;
        end else begin
            ctrl_ff <= cbase;
            ctrl_ff[timer_pkg::OVERFLOW_FLAG_0_BIT] <=
                cbase[timer_pkg::OVERFLOW_FLAG_0_BIT] | ovf0;
            ctrl_ff[timer_pkg::OVERFLOW_FLAG_1_BIT] <=
                cbase[timer_pkg::OVERFLOW_FLAG_1_BIT] | ovf1;
            ctrl_ff[timer_pkg::EDGE_FLAG_0_BIT] <= cbase[timer_pkg::EDGE_FLAG_0_BIT] | ext_set[0];
            ctrl_ff[timer_pkg::EDGE_FLAG_1_BIT] <= cbase[timer_pkg::EDGE_FLAG_1_BIT] | ext_set[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status, write-one-to-clear, set wins
    logic [3:0] ev;
    logic [3:0] clr;
    assign ev = {ext_set[1], ext_set[0], ovf1, ovf0};
    assign clr = (wr & (wb_adr_i == timer_pkg::IRQ_CLEAR_OFS)) ? wb_dat_i[3:0] : 4'h0;
    assign irq_o = |(irq_status_ff & irq_enable_ff);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_status_ff <= timer_pkg::IRQ_RESET;
            irq_enable_ff <= timer_pkg::IRQ_RESET;
        end else begin
            irq_status_ff <= (irq_status_ff & ~clr) | ev;
            if (wr & (wb_adr_i == timer_pkg::IRQ_ENABLE_OFS)) begin
                irq_enable_ff <= wb_dat_i[3:0];
            end
        end
    end
endmodule

// >>> verif/pin_source.sv
// Far-side model of the count and gate pins, idle high
`timescale 1ns/1ps
module pin_source (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] fall_req,
    input wire logic [3:0] hold_low,
    output logic [3:0] pins
);
    logic [4:0] low_cnt_ff [4];
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (rst) begin
                low_cnt_ff[i] <= 5'h00;
            end else if (fall_req[i]) begin
                low_cnt_ff[i] <= 5'h18; // Two machine cycles low
            end else if (low_cnt_ff[i] != 5'h00) begin
                low_cnt_ff[i] <= low_cnt_ff[i] - 5'h01;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pins[i] = !hold_low[i] && low_cnt_ff[i] == 5'h00;
        end
    end
endmodule

// >>> verif/dual_timer_counter_unit_checker.sv
// Port-level assertions for the dual timer/counter unit
`timescale 1ns/1ps
module dual_timer_counter_unit_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_gate_pin_0,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Shadow of the interrupt enable, since the checker cannot see inside
    logic [3:0] en_ff;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_ff <= 4'h0;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == timer_pkg::IRQ_ENABLE_OFS) begin
            en_ff <= wb_dat_i[3:0];
        end
    end
    ////////////////////////////////////////
    a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_upper_zero: assert property (wb_dat_o[31:8] == 24'h000000)
        else $error("read upper bits set");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i > timer_pkg::IRQ_CLEAR_OFS |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_masked_quiet: assert property (en_ff == 4'h0 |-> !irq_o)
        else $error("irq while masked");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !wb_ack_o && !irq_o)
        else $error("outputs active after reset");
    a_edge_irq_raise: assert property (en_ff[2] && $fell(irq_gate_pin_0)
        |-> ##[1:6] irq_o)
        else $error("gate fall raised no irq");
    c_irq: cover property ($rose(irq_o));
    c_unmapped: cover property (wb_ack_o && wb_adr_i > timer_pkg::IRQ_CLEAR_OFS);
    c_gate_fall: cover property (en_ff[2] && $fell(irq_gate_pin_0));
endmodule
bind dual_timer_counter_unit dual_timer_counter_unit_checker chk (.sys_clk(sys_clk),
    .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_gate_pin_0(irq_gate_pin_0), .irq_o(irq_o));

// >>> verif/tb_dual_timer_counter_unit.sv
// Self-checking bench for the dual timer/counter unit
`timescale 1ns/1ps
module tb_dual_timer_counter_unit;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF, svc_ack = 4'h0, fall_req = 4'h0, hold_low = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o;
    logic [3:0] pins;
    logic [7:0] rd;
    int mismatches = 0, total_checks = 0, cycles = 0;
    always #5 sys_clk = ~sys_clk;
    pin_source model (.sys_clk(sys_clk), .rst(rst), .fall_req(fall_req),
        .hold_low(hold_low), .pins(pins));
    dual_timer_counter_unit dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .count_pin_0(pins[0]), .count_pin_1(pins[1]), .irq_gate_pin_0(pins[2]),
        .irq_gate_pin_1(pins[3]), .svc_ack(svc_ack), .irq_o(irq_o));
    ////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; the wait is bounded only by the global timeout
    task automatic acc(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, dat};
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        acc(1'b1, adr, dat);
    endtask
    task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
        acc(1'b0, adr, 8'h00);
        check(rd, exp);
    endtask
    // Run until the flag shows, stop within one machine cycle, then read the counts
    task automatic tmr(input logic [7:0] mode, lo_ofs, hi_ofs, lo, hi, run, flag, elo, ehi);
        wr(timer_pkg::MODE_OFS, mode);
        wr(lo_ofs, lo);
        wr(hi_ofs, hi);
        wr(timer_pkg::CTRL_OFS, run);
        do begin
            acc(1'b0, timer_pkg::CTRL_OFS, 8'h00);
        end while ((rd & flag) == 8'h00);
        wr(timer_pkg::CTRL_OFS, 8'h00);
        rdchk(lo_ofs, elo);
        rdchk(hi_ofs, ehi);
        rdchk(timer_pkg::CTRL_OFS, 8'h00);
    endtask
    task automatic stays(input logic [7:0] mode, ofs, run);
        wr(timer_pkg::MODE_OFS, mode);
        wr(ofs, 8'h05);
        wr(timer_pkg::CTRL_OFS, run);
        repeat (40) @(posedge sys_clk);
        rdchk(ofs, 8'h05);
        wr(timer_pkg::CTRL_OFS, 8'h00);
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 0; a < 32; a += 4) rdchk(8'(a), 8'h00);
        rdchk(8'h40, 8'h00);
        $display("test reset done");
        tmr(8'h01, timer_pkg::LOW0_OFS, timer_pkg::HIGH0_OFS,
            8'hFE, 8'hFF, 8'h10, 8'h20, 8'h00, 8'h00);
        tmr(8'h00, timer_pkg::LOW0_OFS, timer_pkg::HIGH0_OFS,
            8'hFE, 8'hFF, 8'h10, 8'h20, 8'h00, 8'h00);
        // Timer 1 also in reload mode keeps the pairing legal
        tmr(8'h22, timer_pkg::LOW0_OFS, timer_pkg::HIGH0_OFS,
            8'hFE, 8'h80, 8'h10, 8'h20, 8'h80, 8'h80);
        tmr(8'h33, timer_pkg::LOW0_OFS, timer_pkg::HIGH0_OFS,
            8'hFE, 8'h00, 8'h10, 8'h20, 8'h00, 8'h00);
        tmr(8'h33, timer_pkg::HIGH0_OFS, timer_pkg::LOW0_OFS,
            8'hFE, 8'h00, 8'h40, 8'h80, 8'h00, 8'h00);
        tmr(8'h10, timer_pkg::LOW1_OFS, timer_pkg::HIGH1_OFS,
            8'hFE, 8'hFF, 8'h40, 8'h80, 8'h00, 8'h00);
        // Run and stop commits lie 120 clocks apart: exactly ten machine cycles
        wr(timer_pkg::MODE_OFS, 8'h01);
        wr(timer_pkg::LOW0_OFS, 8'h00);
        wr(timer_pkg::HIGH0_OFS, 8'h00);
        wr(timer_pkg::CTRL_OFS, 8'h10);
        repeat (10 * timer_pkg::CLKS_PER_MACHINE_CYCLE - 3) @(posedge sys_clk);
        wr(timer_pkg::CTRL_OFS, 8'h00);
        rdchk(timer_pkg::LOW0_OFS, 8'h0A);
        $display("test modes done");
        stays(8'h01, timer_pkg::LOW0_OFS, 8'h00);
        stays(8'h30, timer_pkg::LOW1_OFS, 8'h40);
        hold_low <= 4'h4;
        stays(8'h09, timer_pkg::LOW0_OFS, 8'h10);
        hold_low <= 4'h0;
        wr(timer_pkg::MODE_OFS, 8'h0D);
        wr(timer_pkg::LOW0_OFS, 8'h00);
        wr(timer_pkg::CTRL_OFS, 8'h10);
        repeat (3) begin
            fall_req <= 4'h1;
            @(posedge sys_clk);
            fall_req <= 4'h0;
            repeat (40) @(posedge sys_clk);
        end
        rdchk(timer_pkg::LOW0_OFS, 8'h03);
        $display("test gating done");
        wr(timer_pkg::IRQ_CLEAR_OFS, 8'h0F);
        wr(timer_pkg::IRQ_STATUS_OFS, 8'h0F);
        rdchk(timer_pkg::IRQ_STATUS_OFS, 8'h00);
        tmr(8'h01, timer_pkg::LOW0_OFS, timer_pkg::HIGH0_OFS,
            8'hFE, 8'hFF, 8'h10, 8'h20, 8'h00, 8'h00);
        rdchk(timer_pkg::IRQ_STATUS_OFS, 8'h01);
        check({7'h00, irq_o}, 8'h00);
        wr(timer_pkg::IRQ_ENABLE_OFS, 8'h01);
        check({7'h00, irq_o}, 8'h01);
        wr(timer_pkg::IRQ_CLEAR_OFS, 8'h01);
        check({7'h00, irq_o}, 8'h00);
        wr(8'h40, 8'hFF);
        rdchk(8'h40, 8'h00);
        wr(timer_pkg::CTRL_OFS, 8'h01);
        wr(timer_pkg::IRQ_ENABLE_OFS, 8'h04);
        fall_req <= 4'h4;
        @(posedge sys_clk);
        fall_req <= 4'h0;
        repeat (8) @(posedge sys_clk);
        check({7'h00, irq_o}, 8'h01);
        rdchk(timer_pkg::CTRL_OFS, 8'h03);
        repeat (30) @(posedge sys_clk);
        svc_ack <= 4'h4;
        @(posedge sys_clk);
        svc_ack <= 4'h0;
        rdchk(timer_pkg::CTRL_OFS, 8'h01);
        wr(timer_pkg::CTRL_OFS, 8'h00);
        hold_low <= 4'h4;
        repeat (10) @(posedge sys_clk);
        svc_ack <= 4'h4;
        @(posedge sys_clk);
        svc_ack <= 4'h0;
        repeat (4) @(posedge sys_clk);
        rdchk(timer_pkg::CTRL_OFS, 8'h02);
        // Let the released gate pin settle through the synchroniser first
        hold_low <= 4'h0;
        repeat (4) @(posedge sys_clk);
        wr(timer_pkg::CTRL_OFS, 8'h04);
        fall_req <= 4'h8;
        @(posedge sys_clk);
        fall_req <= 4'h0;
        repeat (8) @(posedge sys_clk);
        rdchk(timer_pkg::CTRL_OFS, 8'h0C);
        rdchk(timer_pkg::IRQ_STATUS_OFS, 8'h0C);
        // Keep edge type on pin 1 so its slow rise cannot set a level flag
        wr(timer_pkg::MODE_OFS, 8'h01);
        wr(timer_pkg::LOW0_OFS, 8'hFF);
        wr(timer_pkg::HIGH0_OFS, 8'hFF);
        wr(timer_pkg::CTRL_OFS, 8'h14);
        repeat (12) @(posedge sys_clk);
        rdchk(timer_pkg::CTRL_OFS, 8'h34);
        svc_ack <= 4'h1;
        @(posedge sys_clk);
        svc_ack <= 4'h0;
        rdchk(timer_pkg::CTRL_OFS, 8'h14);
        $display("test interrupts done");
        complete_run();
    end
endmodule
